/* File: dmm_core.v */
/*
 data memory decoder and operand address former for an 8-bit core.
 assumes the core drives the op inputs from its own clock, holds them
 stable while op_valid_in is high, and reads/writes the peripheral
 window outside this block.
*/
`include "dmm_consts.vh"
`default_nettype none
// How it works
// - all ram, pointers, ports in one 8-bit space
// - addresses 00-2F are 48 ram bytes
// - reads of 30-7F return all ones
// - 80-9F and reserved reads are undefined
// - F0-FB are ram used as registers
// - FF is plain ram, no segment switch
// - indirect uses first or second pointer
// - auto modify pointer after access completes
// - direct takes 8-bit address from instruction
// - immediate operand is 8-bit instruction field
// - short immediate loads 4-bit pointer value
// - table load: accumulator gives program low byte
module dmm_core #(
    parameter DATA_W = 8,
    parameter RAM_DEPTH = 48,
    parameter REG_DEPTH = 13
) (
    input wire clk_in,
    input wire reset_n_in,
    input wire clk_en_in,
    input wire op_valid_in,
    input wire [2:0] op_mode_in,
    input wire op_write_in,
    input wire op_ptr_sel_in,
    input wire [7:0] op_field_in,
    input wire [7:0] op_wdata_in,
    input wire [7:0] acc_in,
    input wire [7:0] prog_rdata_in,
    input wire [7:0] peri_rdata_in,
    output reg [7:0] op_addr_out,
    output reg [7:0] op_data_out,
    output reg op_done_out,
    output reg peri_sel_out,
    output reg peri_wr_out,
    output reg [7:0] peri_wdata_out,
    output reg [7:0] prog_addr_lo_out,
    output wire [7:0] ptr_one_out,
    output wire [7:0] ptr_two_out,
    output wire [7:0] stack_pointer_out
);
    // region codes of the data space
    localparam [2:0] RG_RAM = 3'h0;
    localparam [2:0] RG_ONES = 3'h1;
    localparam [2:0] RG_UNDEF = 3'h2;
    localparam [2:0] RG_PERI = 3'h3;
    localparam [2:0] RG_REGS = 3'h4;
    localparam [2:0] RG_PTR2 = 3'h5;
    localparam [2:0] RG_STACK = 3'h6;
    localparam [2:0] RG_PTR1 = 3'h7;

    reg [DATA_W-1:0] ram_q [0:RAM_DEPTH-1];
    reg [DATA_W-1:0] regs_q [0:REG_DEPTH-1];
    reg [7:0] ptr_one_q;
    reg [7:0] ptr_two_q;
    reg [7:0] stack_q;
    reg [7:0] addr_d;
    reg [2:0] region_d;
    reg [7:0] rdata_d;
    reg [7:0] ptr_sel_d;
    reg uses_mem_d;
    reg [3:0] reg_idx_d;

    // map an 8-bit data address onto a region
    function [2:0] region_of;
        input [7:0] a;
        begin
            if (a <= `DMM_RAM_HI)
                region_of = RG_RAM;
            else if (a <= `DMM_ONES_HI)
                region_of = RG_ONES;
            else if (a <= `DMM_UNDEF_HI)
                region_of = RG_UNDEF;
            else if (a <= `DMM_PERI_HI)
                region_of = RG_PERI;
            else if (a == `DMM_PTR2_ADDR)
                region_of = RG_PTR2;
            else if (a == `DMM_STACK_ADDR)
                region_of = RG_STACK;
            else if (a == `DMM_PTR1_ADDR)
                region_of = RG_PTR1;
            else
                region_of = RG_REGS;
        end
    endfunction

    assign ptr_one_out = ptr_one_q;
    assign ptr_two_out = ptr_two_q;
    assign stack_pointer_out = stack_q;

    // operand address formation per mode
    always @* begin
        ptr_sel_d = op_ptr_sel_in ? ptr_two_q : ptr_one_q;
        uses_mem_d = 1'b1;
        case (op_mode_in)
            `DMM_MODE_IND, `DMM_MODE_IND_INC, `DMM_MODE_IND_DEC: begin
                addr_d = ptr_sel_d;
            end
            `DMM_MODE_DIRECT: begin
                addr_d = op_field_in;
            end
            default: begin
                addr_d = ptr_sel_d;
                uses_mem_d = 1'b0;
            end
        endcase
        region_d = region_of(addr_d);
        // F0-FB index 0..11, FF index 12
        reg_idx_d = (addr_d == `DMM_SPARE_ADDR) ? 4'hC : addr_d[3:0];
    end

    // read data mux for memory operands
    always @* begin
        case (region_d)
            RG_RAM: rdata_d = ram_q[addr_d[5:0]];
            RG_ONES: rdata_d = `DMM_ONES_VALUE;
            RG_UNDEF: rdata_d = `DMM_UNDEF_VALUE;
            RG_PERI: rdata_d = peri_rdata_in;
            RG_REGS: rdata_d = regs_q[reg_idx_d];
            RG_PTR2: rdata_d = ptr_two_q;
            RG_STACK: rdata_d = stack_q;
            RG_PTR1: rdata_d = ptr_one_q;
            default: rdata_d = `DMM_UNDEF_VALUE;
        endcase
    end

    // storage, pointer update and registered answer
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            ptr_one_q <= `DMM_PTR_RESET;
            ptr_two_q <= `DMM_PTR_RESET;
            stack_q <= `DMM_STACK_RESET;
            op_addr_out <= 8'h00;
            op_data_out <= 8'h00;
            op_done_out <= 1'b0;
            peri_sel_out <= 1'b0;
            peri_wr_out <= 1'b0;
            peri_wdata_out <= 8'h00;
            prog_addr_lo_out <= 8'h00;
        end else if (clk_en_in) begin
            op_done_out <= op_valid_in;
            peri_sel_out <= op_valid_in && uses_mem_d && (region_d == RG_PERI);
            peri_wr_out <= op_valid_in && uses_mem_d && op_write_in
                && (region_d == RG_PERI);
            peri_wdata_out <= op_wdata_in;
            prog_addr_lo_out <= acc_in;
            if (op_valid_in) begin
                op_addr_out <= addr_d;
                case (op_mode_in)
                    `DMM_MODE_IMM: op_data_out <= op_field_in;
                    `DMM_MODE_SHORT_IMM: op_data_out <= {4'h0, op_field_in[3:0]};
                    `DMM_MODE_TABLE: op_data_out <= prog_rdata_in;
                    default: op_data_out <= rdata_d;
                endcase
                // short immediate loads the first pointer
                if (op_mode_in == `DMM_MODE_SHORT_IMM)
                    ptr_one_q <= {4'h0, op_field_in[3:0]};
                // writes land only in mapped storage
                if (uses_mem_d && op_write_in) begin
                    case (region_d)
                        RG_RAM: ram_q[addr_d[5:0]] <= op_wdata_in;
                        RG_REGS: regs_q[reg_idx_d] <= op_wdata_in;
                        RG_PTR2: ptr_two_q <= op_wdata_in;
                        RG_STACK: stack_q <= op_wdata_in;
                        RG_PTR1: ptr_one_q <= op_wdata_in;
                        default: ;
                    endcase
                end
                // post modify after access, unless the access writes either pointer (FC or FE)
                if ((op_mode_in == `DMM_MODE_IND_INC || op_mode_in == `DMM_MODE_IND_DEC)
                    && !(op_write_in && (region_d == RG_PTR1 || region_d == RG_PTR2))) begin
                    if (op_ptr_sel_in)
                        ptr_two_q <= (op_mode_in == `DMM_MODE_IND_INC)
                            ? ptr_two_q + 8'h01 : ptr_two_q - 8'h01;
                    else
                        ptr_one_q <= (op_mode_in == `DMM_MODE_IND_INC)
                            ? ptr_one_q + 8'h01 : ptr_one_q - 8'h01;
                end
            end
        end
    end
endmodule // dmm_core
`default_nettype wire

/* File: dmm_consts.vh */
/*
 data memory map and operand addressing constants.
 assumes inclusion by dmm_core.v only.
*/
`ifndef DMM_CONSTS_VH
`define DMM_CONSTS_VH
`define DMM_RAM_LO 8'h00
`define DMM_RAM_HI 8'h2F
`define DMM_ONES_LO 8'h30
`define DMM_ONES_HI 8'h7F
`define DMM_UNDEF_LO 8'h80
`define DMM_UNDEF_HI 8'h9F
`define DMM_PERI_LO 8'hA0
`define DMM_PERI_HI 8'hEF
`define DMM_REG_LO 8'hF0
`define DMM_REG_HI 8'hFB
`define DMM_PTR2_ADDR 8'hFC
`define DMM_STACK_ADDR 8'hFD
`define DMM_PTR1_ADDR 8'hFE
`define DMM_SPARE_ADDR 8'hFF
`define DMM_PTR_RESET 8'h00
`define DMM_STACK_RESET 8'h2F
`define DMM_ONES_VALUE 8'hFF
`define DMM_UNDEF_VALUE 8'h00
`define DMM_MODE_IND 3'h0
`define DMM_MODE_IND_INC 3'h1
`define DMM_MODE_IND_DEC 3'h2
`define DMM_MODE_DIRECT 3'h3
`define DMM_MODE_IMM 3'h4
`define DMM_MODE_SHORT_IMM 3'h5
`define DMM_MODE_TABLE 3'h6
`endif

/* File: dmm_monitor.sv */
/* checker for dmm_core ports.
   assumes one clock and a sync active-low reset. */
`default_nettype none
module dmm_monitor (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic op_valid_in,
    input wire logic [2:0] op_mode_in,
    input wire logic op_write_in,
    input wire logic op_ptr_sel_in,
    input wire logic [7:0] op_field_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] op_addr_out,
    input wire logic [7:0] op_data_out,
    input wire logic op_done_out,
    input wire logic [7:0] prog_addr_lo_out,
    input wire logic [7:0] ptr_one_out,
    input wire logic [7:0] ptr_two_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    // accepted request and read flag
    wire tk = reset_n_in & clk_en_in & op_valid_in;
    wire rd = tk & !op_write_in;
    // answers tied to the request, and prog_addr_lo_out to acc_in, one edge earlier
    a_done_follow: assert property (tk |=> op_done_out)
        else $error("done missing");
    a_done_cause: assert property (op_done_out && $past(clk_en_in) |-> $past(tk))
        else $error("stray done");
    a_ind_addr: assert property (tk && op_mode_in == 3'h0 |=>
        op_addr_out == ($past(op_ptr_sel_in) ? $past(ptr_two_out) : $past(ptr_one_out)))
        else $error("indirect address");
    a_post_inc: assert property (rd && op_mode_in == 3'h1 && !op_ptr_sel_in |=>
        ptr_one_out == $past(ptr_one_out) + 8'h01) else $error("post increment");
    a_post_dec: assert property (rd && op_mode_in == 3'h2 && op_ptr_sel_in |=>
        ptr_two_out == $past(ptr_two_out) - 8'h01) else $error("post decrement");
    a_direct_addr: assert property (tk && op_mode_in == 3'h3 |=>
        op_addr_out == $past(op_field_in)) else $error("direct address");
    a_imm_data: assert property (tk && op_mode_in == 3'h4 |=>
        op_data_out == $past(op_field_in)) else $error("immediate data");
    a_short_imm: assert property (tk && op_mode_in == 3'h5 |=>
        ptr_one_out == ($past(op_field_in) & 8'h0F)) else $error("short immediate");
    a_table_low: assert property ($past(reset_n_in) && $past(clk_en_in) |->
        prog_addr_lo_out == $past(acc_in)) else $error("table address");
    a_ones_read: assert property (rd && op_mode_in == 3'h3 && op_field_in inside
        {[8'h30:8'h7F]} |=> op_data_out == 8'hFF) else $error("ones read");
    // main scenarios
    c_table: cover property (tk && op_mode_in == 3'h6);
    c_inc: cover property (rd && op_mode_in == 3'h1);
    c_write: cover property (tk && op_write_in);
endmodule // dmm_monitor
bind dmm_core dmm_monitor i_mon (.*);
`default_nettype wire

/* File: dmm_prog_model.sv */
/* program memory model for table loads.
   assumes the core presents its accumulator as the address. */
`default_nettype none
module dmm_prog_model (
    input wire logic [7:0] addr_in,
    output logic [7:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // distinct byte per address, answered in the same cycle
    assign rdata_out = {addr_in[3:0], addr_in[7:4]} ^ 8'hC3;
endmodule // dmm_prog_model
`default_nettype wire

/* File: dmm_core_test.sv */
/* self-checking bench for dmm_core.
   assumes the design and partner model are compiled first. */
`default_nettype none
module dmm_core_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, reset_n_in = 0, clk_en_in = 1, op_valid_in = 0;
    logic op_write_in = 0, op_ptr_sel_in = 0, op_done_out, peri_sel_out, peri_wr_out;
    logic [2:0] op_mode_in = 0;
    logic [7:0] op_field_in = 0, op_wdata_in = 0, acc_in = 0, peri_rdata_in = 0;
    logic [7:0] prog_rdata_in, op_addr_out, op_data_out, peri_wdata_out, prog_addr_lo_out;
    logic [7:0] ptr_one_out, ptr_two_out, stack_pointer_out;
    logic [7:0] mem [256];
    int mismatches = 0, n_tests = 0;
    dmm_core i_dut (.*);
    dmm_prog_model i_prog (.addr_in(acc_in), .rdata_out(prog_rdata_in));
    initial forever #25 clk_in = ~clk_in;
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // expected read value of a data address
    function automatic logic [7:0] rd(input logic [7:0] a, pd);
        if (a <= 8'h2F || a >= 8'hF0) return mem[a];
        if (a <= 8'h7F) return 8'hFF;
        return a <= 8'h9F ? 8'h00 : pd;
    endfunction
    // one request, then its answer checked
    task automatic op(input logic [2:0] m, input logic w, s, input logic [7:0] f, d);
        logic [7:0] a, pd, ac, e;
        a = m == 3'h3 ? f : mem[s ? 8'hFC : 8'hFE];
        pd = 8'($urandom);
        ac = 8'($urandom);
        if (m > 3'h3 || (m inside {3'h1, 3'h2} && a inside {[8'hFC:8'hFE]})) w = 0;
        e = m == 3'h4 ? f : m == 3'h6 ? {ac[3:0], ac[7:4]} ^ 8'hC3 : rd(a, pd);
        @(posedge clk_in);
        op_valid_in <= 1;
        op_mode_in <= m;
        op_write_in <= w;
        op_ptr_sel_in <= s;
        op_field_in <= f;
        op_wdata_in <= d;
        acc_in <= ac;
        peri_rdata_in <= pd;
        @(posedge clk_in);
        op_valid_in <= 0;
        #1;
        chk("done", {7'h0, op_done_out}, 8'h01);
        chk("prog_lo", prog_addr_lo_out, ac);
        if (m <= 3'h3) chk("addr", op_addr_out, a);
        if (m <= 3'h3) chk("peri", {7'h0, peri_sel_out}, {7'h0, a inside {[8'hA0:8'hEF]}});
        chk("peri_wr", {7'h0, peri_wr_out}, {7'h0, w && a inside {[8'hA0:8'hEF]}});
        chk("peri_wd", peri_wdata_out, d);
        if (!w && m != 3'h5) chk("data", op_data_out, e);
        if (w && (a <= 8'h2F || a >= 8'hF0)) mem[a] = d;
        if (m == 3'h5) mem[8'hFE] = {4'h0, f[3:0]};
        if (m inside {3'h1, 3'h2}) mem[s ? 8'hFC : 8'hFE] += m == 3'h1 ? 8'h01 : 8'hFF;
        chk("ptr1", ptr_one_out, mem[8'hFE]);
        chk("ptr2", ptr_two_out, mem[8'hFC]);
        chk("stack", stack_pointer_out, mem[8'hFD]);
    endtask
    initial begin
        void'($urandom(32'hB34DEB7F));
        mem[8'hFC] = 8'h00;
        mem[8'hFD] = 8'h2F;
        mem[8'hFE] = 8'h00;
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1;
        #1;
        chk("rst_stack", stack_pointer_out, 8'h2F);
        chk("rst_done", {7'h0, op_done_out}, 8'h00);
        // write every address, unused ones included
        for (int i = 0; i < 256; i++) op(3'h3, 1, 0, 8'(i), 8'($urandom));
        op(3'h5, 0, 0, 8'hAF, 8'h00);
        op(3'h2, 0, 0, 8'h00, 8'h00);
        repeat (400) op(3'($urandom_range(6)), 1'($urandom), 1'($urandom), 8'($urandom),
            8'($urandom));
        // a request while the clock enable is low must leave all state alone
        @(posedge clk_in);
        clk_en_in <= 0;
        op_valid_in <= 1;
        op_mode_in <= 3'h5;
        op_field_in <= 8'h03;
        @(posedge clk_in);
        #1;
        chk("frz_done", {7'h0, op_done_out}, 8'h00);
        chk("frz_ptr1", ptr_one_out, mem[8'hFE]);
        @(posedge clk_in);
        clk_en_in <= 1;
        op_valid_in <= 0;
        @(posedge clk_in);
        #1;
        chk("frz_ptr1b", ptr_one_out, mem[8'hFE]);
        stop_test;
    end
    // cut a hang short
    initial begin
        repeat (100000) @(posedge clk_in);
        mismatches++;
        stop_test;
    end
endmodule // dmm_core_test
`default_nettype wire
